/* File: rtl/arnv_reset_control.sv */
// module: add-on reset and nv memory control register with arbitration
`timescale 1ns/1ns
// Notes on behaviour
// - opcode bits decode: 0xx none, 100 low, 101 high, 110 write, 111 read
// - enable/ready reads one while an add-on nv access is pending or busy, zero when ready
// - add-on and pci nv requests are arbitrated so both may issue freely
// - failed flag set when the last add-on nv read or write did not complete
// - failed flag clears automatically when the next add-on nv operation starts
// - writing one to bit 27 empties all incoming and outgoing mailbox flags
// - bit 27 produces a one-shot internal pulse, no write-back needed
// - bit 27 always reads zero
// - port byte carries address/data on writes, read result after a read
// - bit 25 pulses a read fifo reset, write only, only when pass-thru idle
module arnv_reset_control
  import arnv_pkg::*;
#(
  parameter int QUARTER = ARNV_QUARTER_CYC
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  addOnAddr,
  input  wire logic        addOnWr,
  input  wire logic        addOnRd,
  input  wire logic [3:0]  addOnBe,
  input  wire logic [31:0] addOnWrData,
  output logic      [31:0] addOnRdData,
  input  wire logic        pciReq,
  input  wire logic        pciIsRead,
  input  wire logic [15:0] pciAddr,
  input  wire logic [7:0]  pciWrData,
  output logic             pciGrant,
  output logic             pciDone,
  output logic             pciFailed,
  output logic [7:0]       pciRdData,
  input  wire logic [3:0]  bistCode,
  input  wire logic        passThruActive,
  output logic             mboxFlagReset,
  output logic             readFifoReset,
  input  wire logic        nvSdaPin,
  output logic             nvSclOe,
  output logic             nvSdaOe
);
  logic [7:0]  addrLo_r;
  logic [7:0]  addrHi_r;
  logic [7:0]  port_r;
  logic        aoPending_r;
  logic        aoIsRead_r;
  logic        aoOwner_r;
  logic        aoFailed_r;
  logic        engStart_r;
  logic        engIsRead_r;
  logic [15:0] engAddr_r;
  logic [7:0]  engData_r;
  logic        engBusy;
  logic        engFailed;
  logic        engBusyDly_r;
  logic [7:0]  engRdData;
  logic [2:0]  sdaSync_r;
  logic        sdaStable_r;

  wire hit    = (addOnAddr == ARNV_CTRL_OFFSET);
  wire wrHit  = addOnWr && hit;
  wire hiLane = wrHit && addOnBe[3];
  wire enBit  = addOnWrData[ARNV_ENABLE_READY_BIT];
  wire [1:0] opc = {addOnWrData[ARNV_OPCODE_HIGH_BIT], addOnWrData[ARNV_OPCODE_LOW_BIT]};
  wire aoBusy = aoPending_r || (engBusy && aoOwner_r) || (engStart_r && aoOwner_r) || (engBusyDly_r && aoOwner_r);
  wire engDone = engBusyDly_r && !engBusy;

  // three-stage pin synchroniser, change accepted when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sdaSync_r   <= 3'b111;
      sdaStable_r <= 1'b1;
    end
    else if (ce)
    begin
      sdaSync_r <= {sdaSync_r[1:0], nvSdaPin};
      if (sdaSync_r[1] == sdaSync_r[2]) sdaStable_r <= sdaSync_r[2];
    end
  end

  // opcode decode of add-on writes, port byte loads
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addrLo_r    <= 8'h00;
      addrHi_r    <= 8'h00;
      port_r      <= 8'h00;
      aoPending_r <= 1'b0;
      aoIsRead_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (hiLane && enBit && !aoBusy && addOnBe[2])
      begin
        case (arnv_op_t'(opc))
          ARNV_OP_LOW:   addrLo_r <= addOnWrData[ARNV_PORT_MSB:ARNV_PORT_LSB];
          ARNV_OP_HIGH:  addrHi_r <= addOnWrData[ARNV_PORT_MSB:ARNV_PORT_LSB];
          ARNV_OP_WRITE:
          begin
            port_r      <= addOnWrData[ARNV_PORT_MSB:ARNV_PORT_LSB];
            aoPending_r <= 1'b1;
            aoIsRead_r  <= 1'b0;
          end
          ARNV_OP_READ:
          begin
            aoPending_r <= 1'b1;
            aoIsRead_r  <= 1'b1;
          end
          default:       aoPending_r <= aoPending_r;
        endcase
      end
      if (engStart_r && aoOwner_r) aoPending_r <= 1'b0;
      if (engDone && aoOwner_r && aoIsRead_r) port_r <= engRdData;
    end
  end

  // arbiter: one engine, round-robin between add-on and pci requests
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      engStart_r   <= 1'b0;
      engIsRead_r  <= 1'b0;
      engAddr_r    <= 16'h0000;
      engData_r    <= 8'h00;
      aoOwner_r    <= 1'b0;
      pciGrant     <= 1'b0;
      engBusyDly_r <= 1'b0;
    end
    else if (ce)
    begin
      engBusyDly_r <= engBusy;
      engStart_r <= 1'b0;
      pciGrant <= 1'b0;
      if (!engBusy && !engStart_r && !engBusyDly_r)
      begin
        if (aoPending_r && (!pciReq || !aoOwner_r))
        begin
          engStart_r  <= 1'b1;
          aoOwner_r   <= 1'b1;
          engIsRead_r <= aoIsRead_r;
          engAddr_r   <= {addrHi_r, addrLo_r};
          engData_r   <= port_r;
        end
        else if (pciReq)
        begin
          engStart_r  <= 1'b1;
          aoOwner_r   <= 1'b0;
          pciGrant    <= 1'b1;
          engIsRead_r <= pciIsRead;
          engAddr_r   <= pciAddr;
          engData_r   <= pciWrData;
        end
      end
    end
  end

  // completion status for each side
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aoFailed_r <= 1'b0;
      pciDone    <= 1'b0;
      pciFailed  <= 1'b0;
      pciRdData  <= 8'h00;
    end
    else if (ce)
    begin
      pciDone <= engDone && !aoOwner_r;
      if (engStart_r && aoOwner_r) aoFailed_r <= 1'b0;
      if (engDone && aoOwner_r) aoFailed_r <= engFailed;
      if (engDone && !aoOwner_r)
      begin
        pciFailed <= engFailed;
        pciRdData <= engRdData;
      end
    end
  end

  // one-shot reset pulses from write-only bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mboxFlagReset <= 1'b0;
      readFifoReset <= 1'b0;
    end
    else if (ce)
    begin
      mboxFlagReset <= hiLane && addOnWrData[ARNV_MBOX_RESET_BIT];
      readFifoReset <= hiLane && addOnWrData[ARNV_RDFIFO_RESET_BIT] && !passThruActive;
    end
  end

  // read data; write-only bits and reserved bits read zero
  always_ff @(posedge clk)
  begin
    if (reset) addOnRdData <= ARNV_CTRL_RESET;
    else if (ce)
    begin
      addOnRdData <= 32'h0000_0000;
      if (addOnRd && hit)
      begin
        addOnRdData[ARNV_ENABLE_READY_BIT] <= aoBusy;
        addOnRdData[ARNV_FAILED_BIT] <= aoFailed_r;
        addOnRdData[ARNV_PORT_MSB:ARNV_PORT_LSB] <= port_r;
        addOnRdData[ARNV_BIST_MSB:ARNV_BIST_LSB] <= bistCode;
      end
    end
  end

  arnv_serial_engine #(.QUARTER(QUARTER)) engine (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .start  (engStart_r),
    .isRead (engIsRead_r),
    .addr   (engAddr_r),
    .wrData (engData_r),
    .sdaIn  (sdaStable_r),
    .sclOe  (nvSclOe),
    .sdaOe  (nvSdaOe),
    .busy   (engBusy),
    .failed (engFailed),
    .rdData (engRdData)
  );
endmodule

/* File: rtl/arnv_pkg.sv */
// package: register map, field positions and timing constants for the add-on reset/nv control block
package arnv_pkg;
  localparam logic [7:0] ARNV_CTRL_OFFSET = 8'h3C;
  localparam logic [31:0] ARNV_CTRL_RESET = 32'h0000_0000;
  localparam int ARNV_ENABLE_READY_BIT = 31;
  localparam int ARNV_OPCODE_HIGH_BIT = 30;
  localparam int ARNV_OPCODE_LOW_BIT = 29;
  localparam int ARNV_FAILED_BIT = 28;
  localparam int ARNV_MBOX_RESET_BIT = 27;
  localparam int ARNV_RDFIFO_RESET_BIT = 25;
  localparam int ARNV_PORT_LSB = 16;
  localparam int ARNV_PORT_MSB = 23;
  localparam int ARNV_BIST_LSB = 12;
  localparam int ARNV_BIST_MSB = 15;
  // serial clock: 100 kHz two-wire rate, quarter-bit phases
  localparam int ARNV_CLK_HZ = 25000000;
  localparam int ARNV_SCL_HZ = 100000;
  localparam int ARNV_QUARTER_CYC = ARNV_CLK_HZ / (ARNV_SCL_HZ * 4);
  localparam logic [6:0] ARNV_DEV_WRITE = 7'h50;
  typedef enum logic [1:0] {ARNV_OP_LOW, ARNV_OP_HIGH, ARNV_OP_WRITE, ARNV_OP_READ} arnv_op_t;
endpackage

/* File: rtl/arnv_serial_engine.sv */
// module: two-wire serial memory engine doing one random write or read of a byte
`timescale 1ns/1ns
module arnv_serial_engine
  import arnv_pkg::*;
#(
  parameter int QUARTER = ARNV_QUARTER_CYC
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        isRead,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        sdaIn,
  output logic             sclOe,
  output logic             sdaOe,
  output logic             busy,
  output logic             failed,
  output logic [7:0]       rdData
);
  // phases of the serial transaction
  typedef enum {S_IDLE, S_START, S_BIT, S_STOP} arnv_phase_t;
  arnv_phase_t phase_r;
  logic [1:0]  quarter_r;
  logic [15:0] tick_r;
  logic [3:0]  bitIdx_r;   // 0..7 data, 8 = ack slot
  logic [2:0]  byteIdx_r;
  logic [2:0]  lastByte_r;
  logic        restart_r;
  logic [7:0]  shift_r;
  logic        nack_r;
  logic        lastReadByte;

  // byte sequence: devW, addrHi, addrLo, (data | restart devR, read)
  function automatic logic [7:0] byteFor(input logic [2:0] idx);
    case (idx)
      3'h0: byteFor = {ARNV_DEV_WRITE, 1'b0};
      3'h1: byteFor = addr[15:8];
      3'h2: byteFor = addr[7:0];
      3'h3: byteFor = isRead ? {ARNV_DEV_WRITE, 1'b1} : wrData;
      default: byteFor = 8'hFF;
    endcase
  endfunction

  assign lastReadByte = isRead && (byteIdx_r == 3'h4);
  wire tickDone = (tick_r == 16'(QUARTER - 1));

  // phase sequencer; sdaOe/sclOe low means the line is pulled low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_r    <= S_IDLE;
      quarter_r  <= 2'h0;
      tick_r     <= 16'h0000;
      bitIdx_r   <= 4'h0;
      byteIdx_r  <= 3'h0;
      lastByte_r <= 3'h0;
      restart_r  <= 1'b0;
      shift_r    <= 8'h00;
      nack_r     <= 1'b0;
      sclOe      <= 1'b1;
      sdaOe      <= 1'b1;
      busy       <= 1'b0;
      failed     <= 1'b0;
      rdData     <= 8'h00;
    end
    else if (ce)
    begin
      tick_r <= tickDone ? 16'h0000 : tick_r + 16'h0001;
      case (phase_r)
        S_IDLE:
        begin
          tick_r <= 16'h0000;
          if (start)
          begin
            busy       <= 1'b1;
            failed     <= 1'b0;
            nack_r     <= 1'b0;
            byteIdx_r  <= 3'h0;
            lastByte_r <= isRead ? 3'h4 : 3'h3;
            restart_r  <= 1'b0;
            quarter_r  <= 2'h0;
            phase_r    <= S_START;
          end
        end
        S_START: if (tickDone)
        begin
          quarter_r <= quarter_r + 2'h1;
          if (quarter_r == 2'h0)
          begin
            sdaOe <= 1'b1;
            sclOe <= 1'b1;
          end
          if (quarter_r == 2'h1) sdaOe <= 1'b0;
          if (quarter_r == 2'h2) sclOe <= 1'b0;
          if (quarter_r == 2'h3)
          begin
            shift_r  <= byteFor(restart_r ? 3'h3 : byteIdx_r);
            bitIdx_r <= 4'h0;
            phase_r  <= S_BIT;
          end
        end
        S_BIT: if (tickDone)
        begin
          quarter_r <= quarter_r + 2'h1;
          if (quarter_r == 2'h0)
            sdaOe <= (bitIdx_r == 4'h8) || lastReadByte || shift_r[7];  // read byte gets a nack to end it
          if (quarter_r == 2'h1) sclOe <= 1'b1;
          if (quarter_r == 2'h2)
          begin
            if (bitIdx_r == 4'h8) nack_r <= nack_r | (!lastReadByte & sdaIn);
            else if (lastReadByte) rdData <= {rdData[6:0], sdaIn};
          end
          if (quarter_r == 2'h3)
          begin
            sclOe <= 1'b0;
            shift_r <= {shift_r[6:0], 1'b0};
            bitIdx_r <= bitIdx_r + 4'h1;
            if (bitIdx_r == 4'h8)
            begin
              bitIdx_r <= 4'h0;
              if (byteIdx_r == lastByte_r) phase_r <= S_STOP;
              else if (isRead && byteIdx_r == 3'h2 && !restart_r)
              begin
                restart_r <= 1'b1;
                byteIdx_r <= 3'h3;
                phase_r   <= S_START;
              end
              else
              begin
                byteIdx_r <= byteIdx_r + 3'h1;
                shift_r <= byteFor(byteIdx_r + 3'h1);
              end
            end
          end
        end
        S_STOP: if (tickDone)
        begin
          quarter_r <= quarter_r + 2'h1;
          if (quarter_r == 2'h0) sdaOe <= 1'b0;
          if (quarter_r == 2'h1) sclOe <= 1'b1;
          if (quarter_r == 2'h2) sdaOe <= 1'b1;
          if (quarter_r == 2'h3)
          begin
            busy    <= 1'b0;
            failed  <= nack_r;
            phase_r <= S_IDLE;
          end
        end
        default: phase_r <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: dv/arnv_nvram_model.sv */
// model: serial memory on the two-wire nv bus
`timescale 1ns/1ns
module arnv_nvram_model(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nak,
  output logic      rel
);
  logic [7:0] mem [256];
  logic [7:0] sh, lo;
  logic       rd = 1'b0;
  int         bn = 0, yn = 0;
  initial rel = 1'b1;
  // start condition restarts framing
  always @(negedge sda)
    if (scl)
    begin
      bn = 0;
      yn = 0;
      rd = 1'b0;
    end
  // take a bit on the rising clock
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    bn++;
    // a nack after a read byte ends the read, so the line is let go
    if (bn == 9 && sda)
      rd = 1'b0;
  end
  // ack, store, or shift read data on the falling clock
  always @(negedge scl)
  begin
    bn = bn % 9;
    if (bn == 8)
    begin
      rd = yn == 0 ? sh[0] : rd;
      lo = yn == 2 ? sh : lo;
      if (yn == 3 && !rd && !nak)
        mem[lo] = sh;
      rel = nak || (rd && yn > 0);
      yn++;
    end
    else
      rel = !(rd && yn > 0) || mem[lo][7 - bn];
  end
endmodule

/* File: dv/arnv_reset_control_sva.sv */
// checker: port properties of the add-on reset and nv control block
`timescale 1ns/1ns
module arnv_reset_control_sva
  import arnv_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [7:0]  addOnAddr,
  input wire logic        addOnWr,
  input wire logic        addOnRd,
  input wire logic [3:0]  addOnBe,
  input wire logic [31:0] addOnWrData,
  input wire logic [31:0] addOnRdData,
  input wire logic        pciReq,
  input wire logic        pciGrant,
  input wire logic        pciDone,
  input wire logic        pciFailed,
  input wire logic        passThruActive,
  input wire logic        mboxFlagReset,
  input wire logic        readFifoReset
);
  logic acc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // write reaching the action byte
  assign acc = ce && addOnWr && addOnAddr == ARNV_CTRL_OFFSET && addOnBe[3];
  property p_mbox; acc && addOnWrData[27] |=> mboxFlagReset; endproperty
  a_mbox: assert property (p_mbox) else $error("mbox pulse missing");
  property p_mbox_src; mboxFlagReset |-> $past(acc && addOnWrData[27]); endproperty
  a_mbox_src: assert property (p_mbox_src) else $error("stray mbox pulse");
  property p_rd27; addOnRd && addOnAddr == ARNV_CTRL_OFFSET |=> !addOnRdData[27]; endproperty
  a_rd27: assert property (p_rd27) else $error("bit 27 read high");
  property p_fifo; acc && addOnWrData[25] |=> readFifoReset != $past(passThruActive); endproperty
  a_fifo: assert property (p_fifo) else $error("fifo pulse wrong");
  property p_fifo_src; readFifoReset |-> $past(acc && addOnWrData[25] && !passThruActive); endproperty
  a_fifo_src: assert property (p_fifo_src) else $error("stray fifo pulse");
  property p_grant; pciGrant |-> $past(pciReq); endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_grant1; pciGrant |=> !pciGrant; endproperty
  a_grant1: assert property (p_grant1) else $error("grant too long");
  property p_fail; $changed(pciFailed) |-> pciDone || $past(pciDone); endproperty
  a_fail: assert property (p_fail) else $error("fail flag moved alone");
  // main scenarios
  c_mbox: cover property (mboxFlagReset);
  c_fifo: cover property (readFifoReset);
  c_pci: cover property (pciDone && !pciFailed);
endmodule
bind arnv_reset_control arnv_reset_control_sva u_sva (.clk(clk), .reset(reset), .ce(ce), .addOnAddr(addOnAddr),
  .addOnWr(addOnWr), .addOnRd(addOnRd), .addOnBe(addOnBe), .addOnWrData(addOnWrData),
  .addOnRdData(addOnRdData), .pciReq(pciReq), .pciGrant(pciGrant), .pciDone(pciDone), .pciFailed(pciFailed),
  .passThruActive(passThruActive), .mboxFlagReset(mboxFlagReset), .readFifoReset(readFifoReset));

/* File: dv/tb_arnv_reset_control.sv */
// testbench: control register, reset pulses and nv memory traffic
`timescale 1ns/1ns
module tb_arnv_reset_control;
  import arnv_pkg::*;
  logic        clk, reset, ce, addOnWr, addOnRd, pciReq, passThruActive, nak, rel;
  logic        pciGrant, pciDone, pciFailed, mboxFlagReset, readFifoReset, nvSclOe, nvSdaOe;
  logic [3:0]  addOnBe;
  logic [7:0]  addOnAddr, pciRdData;
  logic [31:0] addOnWrData, addOnRdData, d;
  int          badCount = 0, numChecks = 0, mboxCnt = 0, fifoCnt = 0;
  wire         sda = nvSdaOe & rel;
  arnv_reset_control #(.QUARTER(2)) DUT (.clk(clk), .reset(reset), .ce(ce), .addOnAddr(addOnAddr),
    .addOnWr(addOnWr), .addOnRd(addOnRd), .addOnBe(addOnBe), .addOnWrData(addOnWrData),
    .addOnRdData(addOnRdData), .pciReq(pciReq), .pciIsRead(1'b1), .pciAddr(16'h0034), .pciWrData(8'h00),
    .pciGrant(pciGrant), .pciDone(pciDone), .pciFailed(pciFailed), .pciRdData(pciRdData), .bistCode(4'hA),
    .passThruActive(passThruActive), .mboxFlagReset(mboxFlagReset), .readFifoReset(readFifoReset),
    .nvSdaPin(sda), .nvSclOe(nvSclOe), .nvSdaOe(nvSdaOe));
  arnv_nvram_model nvm (.scl(nvSclOe), .sda(sda), .nak(nak), .rel(rel));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one-shot pulse counters
  always @(posedge clk)
  begin
    mboxCnt <= mboxCnt + int'(mboxFlagReset);
    fifoCnt <= fifoCnt + int'(readFifoReset);
  end
  task automatic completeRun;
    $display("checks %0d wrong %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic regWr(logic [31:0] v);
    addOnWr     <= 1'b1;
    addOnWrData <= v;
    @(posedge clk);
    addOnWr     <= 1'b0;
    @(posedge clk);
  endtask
  // read data is taken the cycle after the strobe
  task automatic regRd(logic [7:0] a);
    addOnRd   <= 1'b1;
    addOnAddr <= a;
    @(posedge clk);
    addOnRd   <= 1'b0;
    addOnAddr <= ARNV_CTRL_OFFSET;
    @(posedge clk);
    d = addOnRdData;
  endtask
  task automatic rdChk(string what, logic [31:0] mask, logic [31:0] exp);
    regRd(ARNV_CTRL_OFFSET);
    check(what, d & mask, exp);
  endtask
  task automatic nvWait;
    for (int i = 0; i < 3000; i++)
    begin
      regRd(ARNV_CTRL_OFFSET);
      if (d[31] === 1'b0)
        return;
    end
    check("ready", d, 32'h0);
    completeRun();
  endtask
  task automatic nvStep(logic [31:0] v);
    regWr(v);
    nvWait();
  endtask
  // mailbox and read fifo one-shots, refused variants
  task automatic scnPulses;
    rdChk("reset value", 32'hFFFF_FFFF, 32'h0000_A000);
    regRd(8'h40);
    check("unmapped", d, 32'h0);
    regWr(32'h0800_0000);
    regWr(32'h0800_0000);
    // frozen clock enable: this write must leave no pulse
    ce <= 1'b0;
    regWr(32'h0800_0000);
    ce <= 1'b1;
    addOnBe <= 4'h7;
    regWr(32'h0A00_0000);
    addOnBe <= 4'hF;
    passThruActive <= 1'b1;
    regWr(32'h0200_0000);
    passThruActive <= 1'b0;
    regWr(32'h0200_0000);
    rdChk("bit 27 read", 32'h0800_0000, 32'h0);
    check("mailbox pulses", mboxCnt, 2);
    check("fifo pulses", fifoCnt, 1);
  endtask
  // write sequence, with a step refused while busy
  task automatic scnNvWrite;
    regWr(32'h6012_0000);
    rdChk("inactive op", 32'h8000_0000, 32'h0);
    nvStep(32'h8034_0000);
    nvStep(32'hA000_0000);
    regWr(32'hC05A_0000);
    regWr(32'hC0FF_0000);
    rdChk("busy", 32'h8000_0000, 32'h8000_0000);
    nvWait();
    check("write status", d & 32'h1000_0000, 32'h0);
  endtask
  // read back while the pci side asks for the same byte
  task automatic scnNvRead;
    nvStep(32'h8034_0000);
    nvStep(32'hA000_0000);
    regWr(32'hE000_0000);
    pciReq <= 1'b1;
    for (int i = 0; i < 3000 && pciDone !== 1'b1; i++)
    begin
      @(posedge clk);
      if (pciGrant === 1'b1)
        pciReq <= 1'b0;
    end
    check("pci read", {22'h0, pciDone, pciFailed, pciRdData}, 32'h0000_025A);
    if (pciDone !== 1'b1)
      completeRun();
    nvWait();
    check("read byte", d & 32'h10FF_0000, 32'h005A_0000);
  endtask
  // a refused byte fails the access; the next start clears it
  task automatic scnNack;
    nak = 1'b1;
    nvStep(32'h8034_0000);
    nvStep(32'hA000_0000);
    nvStep(32'hC077_0000);
    check("nack", d & 32'h1000_0000, 32'h1000_0000);
    nak = 1'b0;
    regWr(32'hE000_0000);
    // the flag clears once the engine has taken the start
    @(posedge clk);
    rdChk("restart", 32'h9000_0000, 32'h8000_0000);
    nvWait();
    check("kept byte", d & 32'h10FF_0000, 32'h005A_0000);
  endtask
  // main sequence
  initial
  begin
    reset          = 1'b1;
    ce             = 1'b1;
    addOnWr        = 1'b0;
    addOnRd        = 1'b0;
    addOnAddr      = ARNV_CTRL_OFFSET;
    addOnBe        = 4'hF;
    addOnWrData    = 32'h0;
    pciReq         = 1'b0;
    passThruActive = 1'b0;
    nak            = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    scnPulses();
    scnNvWrite();
    scnNvRead();
    scnNack();
    completeRun();
  end
endmodule
